// ### hw/hsio_top.sv
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// [R1] function code acts only with chip select low and code nonzero
// [R2] stop codes halt core after current cycle; resume on code change
// [R3] host holds each code at least one instruction cycle
// [R4] host keeps stop halts within ten microseconds
// [R5] read/write pin sets transfer direction; read drives, write captures
// [R6] code 0010 moves low byte, no interrupt
// [R7] code 0011 moves upper byte or full word; may interrupt
// [R8] code 0100 writes control bits 0-7 and stops
// [R9] code 1000 loads pc, sets global mask, stops
// [R10] control and pc loads halt core, latch data on strobe
// [R11] serial input msb first, short words aligned to top bit
// [R12] converter supplies more than sixteen input clocks
// [R13] serial input read refused while busy; read clears it
// [R14] input bits beyond sixteenth ignored
// [R15] input count starts at enable rise; done after sixteen bits
// [R16] serial output msb first; pin released while enable low
// [R17] output zero from sixteenth clock; register left zero
// [R18] converter drops output enable after wanted bit count
// [R19] output done at enable fall; load on core transfer
// [R20] one interrupt level, three sources, software identifies
// [R21] interrupt loads pc with last rom address
// [R22] global mask set on take, cleared on return; masks writable
// [R23] done flags set even while masked
// [R24] two-entry pc return stack; two accumulators
// [R25] interrupts deferred while core reports busy instruction
// [R26] status read clears three done flags
// [R27] parallel done at strobe trailing edge, byte mode after upper
// [R28] interrupt request when flag set and both masks clear
module hsio_top
    import hsio_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // host parallel port
    input wire logic chipSelect_n,
    input wire logic [3:0] function_code,
    input wire logic readNotWrite,
    input wire logic io_strobe,
    input wire logic [15:0] dataIn,
    output logic [15:0] dataOut,
    output logic dataOutEn,
    // serial converters
    input wire logic serial_input_clock,
    input wire logic serial_input_enable,
    input wire logic serialIn,
    input wire logic serial_output_clock,
    input wire logic serial_output_enable,
    output logic serialOut,
    output logic serialOutEn,
    // core status
    output logic coreHalt,
    output logic intRequest,
    output logic [8:0] progCounter,
    output logic accSelect,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [1:0] {
        RUN = 2'b00,
        STOP = 2'b01
    } hsio_mode_t;

    // two-flop synchronisers for every host port and serial converter pin
    localparam int NSYNC = 28;
    logic [NSYNC-1:0] pinMeta_reg;
    logic [NSYNC-1:0] pinSync_reg;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pinMeta_reg <= '0;
            pinSync_reg <= '0;
        end else begin
            pinMeta_reg <= {dataIn, function_code, io_strobe, readNotWrite,
                !chipSelect_n, serial_input_clock, serial_input_enable,
                serialIn, serial_output_clock, serial_output_enable};
            pinSync_reg <= pinMeta_reg;
        end
    end
    wire [15:0] pData = pinSync_reg[27:12];
    wire [3:0] fCode = pinSync_reg[11:8];
    wire strobe = pinSync_reg[7];
    wire rdNwr = pinSync_reg[6];
    wire csel = pinSync_reg[5];
    wire siClkS, siEnS, siDatS, soClkS, soEnS;
    assign {siClkS, siEnS, siDatS, soClkS, soEnS} = pinSync_reg[4:0];

    function automatic logic codeActive(input logic cs, input logic [3:0] c);
        return cs && c != FC_IDLE; // [R1]
    endfunction

    // registers
    logic [7:0] status_reg;
    logic [7:0] control_reg;
    logic [15:0] parallel_in_reg;
    logic [15:0] parallelOut_reg;
    logic [8:0] pc_reg;
    logic [8:0] stack0_reg;
    logic [8:0] stack1_reg;
    logic [1:0] depth_reg;
    logic accSel_reg;
    logic coreBusy_reg;
    hsio_mode_t mode_reg;
    logic strobePrev_reg;
    logic [5:0] cycleCnt_reg;
    logic [3:0] stopCode_reg;

    logic siClear, soLoad, siDone, soDone, siBusy;
    logic [15:0] siData, soData;
    logic [15:0] soLoadData;

    hsio_serial_in uSerIn (
        .core_clk(core_clk),
        .rst(rst),
        .sClk(siClkS),
        .sEn(siEnS),
        .sData(siDatS),
        .clearReq(siClear),
        .shiftReg(siData),
        .busy(siBusy),
        .donePulse(siDone)
    );

    hsio_serial_out uSerOut (
        .core_clk(core_clk),
        .rst(rst),
        .sClk(soClkS),
        .sEn(soEnS),
        .loadReq(soLoad),
        .loadData(soLoadData),
        .shiftReg(soData),
        .dataOut(serialOut),
        .dataOutEn(serialOutEn),
        .donePulse(soDone)
    );

    // axi4-lite slave: one write, one read at a time
    logic awHeld_reg, wHeld_reg;
    logic [7:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
    wire wrFire = awHeld_reg && wHeld_reg;
    wire rdFire = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            awAddr_reg <= 8'h00;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_reg <= 1'b1;
                awAddr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_reg <= 1'b1;
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_reg <= 1'b0;
                wHeld_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awAddr_reg > ADDR_CORE)
                    ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire wrEn = wrFire && wStrb_reg[0];
    wire wrStatus = wrEn && awAddr_reg == ADDR_STATUS;
    wire wrControl = wrEn && awAddr_reg == ADDR_CONTROL;
    wire wrPout = wrFire && awAddr_reg == ADDR_POUT;
    wire wrCore = wrEn && awAddr_reg == ADDR_CORE;
    wire rdStatus = rdFire && s_axi_araddr == ADDR_STATUS;
    wire rdSin = rdFire && s_axi_araddr == ADDR_SIN && !siBusy;
    wire takeInt = wrCore && wData_reg[CMD_TAKE_INT];
    wire doRti = wrCore && wData_reg[CMD_RTI];
    wire doCall = wrCore && wData_reg[CMD_CALL];
    wire doRtn = wrCore && wData_reg[CMD_RTN];
    assign soLoad = wrFire && awAddr_reg == ADDR_SOUT; // [R19]
    assign soLoadData = wData_reg[15:0];
    assign siClear = rdSin; // [R13]

    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (rdFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_STATUS: s_axi_rdata <= {24'h0, status_reg};
                ADDR_CONTROL: s_axi_rdata <= {24'h0, control_reg};
                ADDR_PIN: s_axi_rdata <= {16'h0, parallel_in_reg};
                ADDR_POUT: s_axi_rdata <= {16'h0, parallelOut_reg};
                ADDR_SIN: begin
                    s_axi_rdata <= {16'h0, siData};
                    if (siBusy) begin
                        s_axi_rresp <= RESP_SLVERR; // [R13]
                    end
                end
                ADDR_SOUT: s_axi_rdata <= {16'h0, soData};
                ADDR_CORE: s_axi_rdata <= {26'h0, accSel_reg,
                    coreBusy_reg, depth_reg, mode_reg == STOP, 1'b0};
                ADDR_PC: s_axi_rdata <= {23'h0, pc_reg};
                ADDR_STACK: s_axi_rdata <= {5'h0, stack1_reg,
                    7'h0, stack0_reg, 2'h0};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // parallel port: strobe trailing edge ends a transfer
    wire active = codeActive(csel, fCode);
    wire strobeFall = strobePrev_reg && !strobe && active;
    wire wordMode = control_reg[CT_WB];
    always_ff @(posedge core_clk) begin
        if (rst) begin
            strobePrev_reg <= 1'b0;
            parallel_in_reg <= 16'h0000;
        end else begin
            strobePrev_reg <= strobe;
            if (strobeFall && !rdNwr) begin // [R5]
                if (fCode == FC_LOW) begin
                    parallel_in_reg[7:0] <= pData[7:0]; // [R6]
                end else if (fCode == FC_UPPER && wordMode) begin
                    parallel_in_reg <= pData; // [R7]
                end else if (fCode == FC_UPPER) begin
                    parallel_in_reg[15:8] <= pData[7:0]; // [R7]
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            parallelOut_reg <= 16'h0000;
        end else if (wrPout) begin
            parallelOut_reg <= wData_reg[15:0];
        end
    end

    // read drives pins while strobe high [R5]
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dataOut <= 16'h0000;
            dataOutEn <= 1'b0;
        end else begin
            dataOutEn <= active && rdNwr && strobe
                && (fCode == FC_LOW || fCode == FC_UPPER);
            if (fCode == FC_UPPER && wordMode) begin
                dataOut <= parallelOut_reg;
            end else if (fCode == FC_UPPER) begin
                dataOut <= {8'h00, parallelOut_reg[15:8]};
            end else begin
                dataOut <= {8'h00, parallelOut_reg[7:0]};
            end
        end
    end

    // stop mode after instruction cycle ends; exit on code change
    wire isStopCode = active && (fCode == FC_CTRL || fCode == FC_PC);
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cycleCnt_reg <= 6'h00;
        end else if (cycleCnt_reg == 6'(CYCLE_CLKS - 1)) begin
            cycleCnt_reg <= 6'h00;
        end else begin
            cycleCnt_reg <= cycleCnt_reg + 6'h01;
        end
    end
    wire cycleEnd = cycleCnt_reg == 6'(CYCLE_CLKS - 1);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_reg <= RUN;
            stopCode_reg <= FC_IDLE;
        end else begin
            unique case (mode_reg)
                RUN: if (isStopCode && cycleEnd) begin
                    mode_reg <= STOP; // [R2] [R10]
                    stopCode_reg <= fCode;
                end
                STOP: if (!csel || fCode != stopCode_reg) begin
                    mode_reg <= RUN; // [R2]
                end
                default: mode_reg <= RUN;
            endcase
        end
    end
    assign coreHalt = mode_reg == STOP;

    // control register: host loads latch on strobe [R8] [R10]
    wire hostCtl = strobeFall && !rdNwr && fCode == FC_CTRL;
    wire hostPc = strobeFall && !rdNwr && fCode == FC_PC;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            control_reg <= CONTROL_RST;
        end else if (hostCtl) begin
            control_reg <= pData[7:0]; // [R8]
        end else if (wrControl) begin
            control_reg <= wData_reg[7:0];
        end
    end

    // status flags: set wins over read clear [R23] [R26]
    wire pfSet = strobeFall && fCode == FC_UPPER; // [R27]
    always_ff @(posedge core_clk) begin
        if (rst) begin
            status_reg <= STATUS_RST;
        end else begin
            if (wrStatus) begin
                status_reg[ST_UF:ST_IM] <= wData_reg[ST_UF:ST_IM]; // [R22]
            end
            if (rdStatus) begin
                status_reg[ST_SOF:ST_PF] <= 3'b000; // [R26]
            end
            if (pfSet) status_reg[ST_PF] <= 1'b1; // [R23]
            if (siDone) status_reg[ST_SIF] <= 1'b1; // [R23]
            if (soDone) status_reg[ST_SOF] <= 1'b1; // [R23]
            if (doRti) status_reg[ST_IM] <= 1'b0; // [R22]
            if (takeInt && intRequest) status_reg[ST_IM] <= 1'b1; // [R22]
            if (hostPc) status_reg[ST_IM] <= 1'b1; // [R9]
        end
    end

    // one level, three sources [R20] [R28]
    assign intRequest = !status_reg[ST_IM] && !coreBusy_reg && (
        (status_reg[ST_PF] && !status_reg[ST_IP])
        || (status_reg[ST_SIF] && !status_reg[ST_ISI])
        || (status_reg[ST_SOF] && !status_reg[ST_ISO])); // [R25]

    // pc, return stack and accumulator select [R21] [R24]
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pc_reg <= 9'h000;
            stack0_reg <= 9'h000;
            stack1_reg <= 9'h000;
            depth_reg <= 2'h0;
            accSel_reg <= 1'b0;
            coreBusy_reg <= 1'b0;
        end else begin
            if (wrCore) begin
                coreBusy_reg <= wData_reg[CMD_BUSY]; // [R25]
            end
            if (hostPc) begin
                pc_reg <= PC_LOAD_HI | {1'b0, pData[7:0]}; // [R9]
            end else if ((takeInt && intRequest) || doCall) begin
                stack1_reg <= stack0_reg; // [R24]
                stack0_reg <= pc_reg;
                if (depth_reg != 2'h2) depth_reg <= depth_reg + 2'h1;
                pc_reg <= doCall ? wData_reg[16:8] : INT_VECTOR; // [R21]
                if (!doCall) accSel_reg <= 1'b1; // [R24]
            end else if (doRti || doRtn) begin
                pc_reg <= stack0_reg; // [R24]
                stack0_reg <= stack1_reg;
                if (depth_reg != 2'h0) depth_reg <= depth_reg - 2'h1;
                if (doRti) accSel_reg <= 1'b0;
            end else if (wrFire && awAddr_reg == ADDR_PC) begin
                pc_reg <= wData_reg[8:0];
            end
        end
    end
    assign progCounter = pc_reg;
    assign accSelect = accSel_reg;
endmodule

// ### hw/hsio_pkg.sv
package hsio_pkg;
    // function codes
    localparam logic [3:0] FC_IDLE = 4'h0;
    localparam logic [3:0] FC_LOW = 4'h2;
    localparam logic [3:0] FC_UPPER = 4'h3;
    localparam logic [3:0] FC_CTRL = 4'h4;
    localparam logic [3:0] FC_PC = 4'h8;
    // register byte addresses
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_PIN = 8'h08;
    localparam logic [7:0] ADDR_POUT = 8'h0c;
    localparam logic [7:0] ADDR_SIN = 8'h10;
    localparam logic [7:0] ADDR_SOUT = 8'h14;
    localparam logic [7:0] ADDR_CORE = 8'h18;
    localparam logic [7:0] ADDR_PC = 8'h1c;
    localparam logic [7:0] ADDR_STACK = 8'h20;
    // status bit positions
    localparam int ST_PF = 0;
    localparam int ST_SIF = 1;
    localparam int ST_SOF = 2;
    localparam int ST_IM = 3;
    localparam int ST_IP = 4;
    localparam int ST_ISI = 5;
    localparam int ST_ISO = 6;
    localparam int ST_UF = 7;
    // control bit positions
    localparam int CT_WB = 7;
    // core command bits (write to ADDR_CORE)
    localparam int CMD_TAKE_INT = 0;
    localparam int CMD_RTI = 1;
    localparam int CMD_CALL = 2;
    localparam int CMD_RTN = 3;
    localparam int CMD_BUSY = 4;
    localparam int CMD_ACC_SEL = 5;
    // reset and vector values
    localparam logic [7:0] STATUS_RST = 8'h78;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [8:0] INT_VECTOR = 9'h1ff;
    localparam logic [8:0] PC_LOAD_HI = 9'h100;
    localparam int SER_BITS = 16;
    // instruction cycle 250 ns at 5 ns clock
    localparam int CYCLE_NS = 250;
    localparam int CLK_NS = 5;
    localparam int CYCLE_CLKS = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ### hw/hsio_serial_in.sv
`timescale 1ns/1ps
module hsio_serial_in
    import hsio_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    // synchronised link pins
    input wire logic sClk,
    input wire logic sEn,
    input wire logic sData,
    // core side
    input wire logic clearReq,
    output logic [15:0] shiftReg,
    output logic busy,
    output logic donePulse
);
    logic clkPrev_reg;
    logic enPrev_reg;
    logic [4:0] count_reg;
    wire clkRise = sClk && !clkPrev_reg;
    wire enRise = sEn && !enPrev_reg;
    wire shiftOn = clkRise && count_reg != 5'(SER_BITS)
        && (sEn || count_reg != 5'h00);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clkPrev_reg <= 1'b0;
            enPrev_reg <= 1'b0;
        end else begin
            clkPrev_reg <= sClk;
            enPrev_reg <= sEn;
        end
    end

    // count restarts at leading edge of enable [R15]
    always_ff @(posedge core_clk) begin
        if (rst || enRise) begin
            count_reg <= 5'h00;
        end else if (shiftOn) begin
            count_reg <= count_reg + 5'h01;
        end
    end

    // msb first; shifting runs on to sixteen bits after enable falls, so short words reach msb; bits past sixteen dropped
    always_ff @(posedge core_clk) begin
        if (rst || clearReq) begin
            shiftReg <= 16'h0000; // [R13]
        end else if (shiftOn) begin
            shiftReg <= {shiftReg[14:0], sData}; // [R11] [R14]
        end
    end

    assign busy = (sEn || count_reg != 5'h00) && count_reg != 5'(SER_BITS);
    assign donePulse = shiftOn && count_reg == 5'(SER_BITS - 1); // [R15]
endmodule

// ### hw/hsio_serial_out.sv
`timescale 1ns/1ps
module hsio_serial_out
    import hsio_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    // synchronised link pins
    input wire logic sClk,
    input wire logic sEn,
    // core side
    input wire logic loadReq,
    input wire logic [15:0] loadData,
    output logic [15:0] shiftReg,
    output logic dataOut,
    output logic dataOutEn,
    output logic donePulse
);
    logic clkPrev_reg;
    logic enPrev_reg;
    logic [4:0] count_reg;
    wire clkFall = !sClk && clkPrev_reg;
    wire enRise = sEn && !enPrev_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clkPrev_reg <= 1'b0;
            enPrev_reg <= 1'b0;
        end else begin
            clkPrev_reg <= sClk;
            enPrev_reg <= sEn;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst || enRise) begin
            count_reg <= 5'h00;
        end else if (clkFall && sEn && count_reg != 5'(SER_BITS)) begin
            count_reg <= count_reg + 5'h01;
        end
    end

    // msb first, zeros fill behind the data [R16] [R17]
    always_ff @(posedge core_clk) begin
        if (rst) begin
            shiftReg <= 16'h0000;
        end else if (loadReq) begin
            shiftReg <= loadData; // [R19]
        end else if (clkFall && (sEn || enPrev_reg)) begin
            shiftReg <= {shiftReg[14:0], 1'b0}; // [R17]
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            dataOut <= 1'b0;
        end else if (count_reg == 5'(SER_BITS)) begin
            dataOut <= 1'b0; // [R17]
        end else begin
            dataOut <= shiftReg[15];
        end
    end

    assign dataOutEn = sEn; // [R16]
    assign donePulse = !sEn && enPrev_reg; // [R19]
endmodule

// ### tb/hsio_top_assertions.sv
`timescale 1ns/1ps
module hsio_chk
    import hsio_pkg::*;
(
    // clock and reset
    input logic core_clk,
    input logic rst,
    // host port
    input logic chipSelect_n,
    input logic [3:0] function_code,
    input logic readNotWrite,
    input logic dataOutEn,
    // serial and core
    input logic serial_output_enable,
    input logic serialOutEn,
    input logic coreHalt,
    input logic intRequest,
    // bus handshakes
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_rvalid,
    input logic s_axi_rready
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);

    AST_IDLE:
    assert property (chipSelect_n [*4] |-> !dataOutEn)
        else $error("port driven while deselected");
    AST_DIR:
    assert property (!readNotWrite [*4] |-> !dataOutEn)
        else $error("port driven during write");
    AST_SO_OFF:
    assert property (!serial_output_enable [*4] |-> !serialOutEn)
        else $error("serial out driven while disabled");
    AST_SO_ON:
    assert property (serial_output_enable [*4] |-> serialOutEn)
        else $error("serial out not driven while enabled");
    AST_HALT:
    assert property ((!chipSelect_n && function_code == FC_CTRL) [*8]
        |-> ##[0:60] coreHalt) else $error("no stop on control load");
    AST_PC_HALT:
    assert property ((!chipSelect_n && function_code == FC_PC) [*8]
        |-> ##[0:60] coreHalt) else $error("no stop on pc load");
    AST_RESUME:
    assert property (coreHalt && $changed(function_code) |-> ##[1:8] !coreHalt)
        else $error("stop not left on code change");
    AST_BDONE:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    AST_RDONE:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");

    cover property ($rose(coreHalt));
    cover property ($rose(intRequest));
    cover property ($fell(serialOutEn));
endmodule

bind hsio_top hsio_chk chk (.*);

// ### tb/hsio_conv.sv
`timescale 1ns/1ps
module hsio_conv (
    input logic core_clk,
    input logic soPin,
    output logic sClk,
    output logic sEn,
    output logic sData,
    output logic [15:0] outWord
);
    initial begin
        sClk = 1'b0;
        sEn = 1'b0;
        sData = 1'b0;
        outWord = 16'h0000;
    end

    // enable held n clocks, spare clocks up to 20 keep counters moving
    task automatic frame(input logic [15:0] w, input int n);
        for (int i = 0; i < 20; i++) begin
            sEn <= (i < n);
            sData <= (i < n && i < 16) ? w[15 - i] : ~sData;
            repeat (8) @(posedge core_clk);
            sClk <= 1'b1;
            if (i < n) outWord <= {outWord[14:0], soPin};
            repeat (8) @(posedge core_clk);
            sClk <= 1'b0;
        end
        sEn <= 1'b0;
    endtask
endmodule

// ### tb/hsio_top_bench.sv
`timescale 1ns/1ps
module hsio_top_bench;
    import hsio_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, chipSelect_n = 1'b1;
    logic readNotWrite = 1'b0, io_strobe = 1'b0;
    logic [3:0] function_code = FC_IDLE;
    logic [15:0] hostD = 16'h0000, pData, dataOut, outWord;
    logic dataOutEn, serialOut, serialOutEn, coreHalt, intRequest;
    logic accSelect, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [8:0] progCounter;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rVal;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp, rResp;
    logic serial_input_clock, serial_input_enable, serialIn;
    wire [15:0] dataIn = dataOutEn ? dataOut : hostD;
    wire serial_output_clock = serial_input_clock;
    wire serial_output_enable = serial_input_enable;
    wire soLine = serialOutEn ? serialOut : 1'bz;
    int error_cnt = 0, n_checks = 0;

    always #2.5 core_clk = ~core_clk;

    hsio_top dut (.*);
    hsio_conv conv (.core_clk, .soPin(soLine), .sClk(serial_input_clock),
        .sEn(serial_input_enable), .sData(serialIn), .outWord);

    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic done(input int k);
        if (k == 99) begin
            error_cnt++;
            close_out();
        end
        repeat (2) @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int k;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 99; k++) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        done(k);
    endtask

    task automatic rd(input logic [7:0] a);
        int k;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 99; k++) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        rVal = s_axi_rdata;
        rResp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done(k);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        cmp(rVal, exp);
    endtask

    // host cycle: code held well past one instruction cycle
    task automatic port(input logic [3:0] c, input logic r, input logic [15:0] d);
        chipSelect_n <= 1'b0;
        function_code <= c;
        readNotWrite <= r;
        hostD <= r ? ~d : d;
        repeat (4) @(posedge core_clk);
        io_strobe <= 1'b1;
        repeat (8) @(posedge core_clk);
        pData = dataOut;
        io_strobe <= 1'b0;
        repeat (60) @(posedge core_clk);
        chipSelect_n <= 1'b1;
        function_code <= FC_IDLE;
        hostD <= ~hostD;
        repeat (60) @(posedge core_clk);
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rc(ADDR_STATUS, {24'h0, STATUS_RST});
        rd(8'h24);
        cmp({30'h0, rResp}, {30'h0, RESP_SLVERR});
        port(FC_LOW, 1'b0, 16'h00a5);
        rc(ADDR_STATUS, {24'h0, STATUS_RST});
        port(FC_UPPER, 1'b0, 16'h005a);
        rc(ADDR_PIN, 32'h5aa5);
        rc(ADDR_STATUS, 32'h79);
        rc(ADDR_STATUS, 32'h78);
        port(FC_CTRL, 1'b0, 16'h0080);
        rc(ADDR_CONTROL, 32'h80);
        port(FC_UPPER, 1'b0, 16'h1234);
        rc(ADDR_PIN, 32'h1234);
        wr(ADDR_POUT, 32'hbeef);
        port(FC_UPPER, 1'b1, 16'h0000);
        cmp({16'h0, pData}, 32'hbeef);
        wr(ADDR_STATUS, 32'h0);
        cmp({31'h0, intRequest}, 32'h1);
        wr(ADDR_CORE, 32'h1);
        cmp({23'h0, progCounter}, {23'h0, INT_VECTOR});
        cmp({31'h0, intRequest}, 32'h0);
        cmp({31'h0, accSelect}, 32'h1);
        wr(ADDR_CORE, 32'h2);
        cmp({31'h0, accSelect}, 32'h0);
        cmp({31'h0, intRequest}, 32'h1);
        rc(ADDR_STATUS, 32'h01);
        cmp({31'h0, intRequest}, 32'h0);
        port(FC_PC, 1'b0, 16'h0423);
        cmp({23'h0, progCounter}, 32'h123);
        rc(ADDR_STATUS, 32'h08);
        wr(ADDR_SOUT, 32'ha55b);
        cmp({30'h0, s_axi_bresp}, {30'h0, RESP_OKAY});
        conv.frame(16'hc3a5, 16);
        rc(ADDR_SIN, 32'hc3a5);
        cmp({16'h0, outWord}, 32'ha55b);
        rc(ADDR_STATUS, 32'h0e);
        rc(ADDR_SIN, 32'h0);
        rc(ADDR_SOUT, 32'h0);
        wr(ADDR_SOUT, 32'h0ff0);
        conv.frame(16'h9876, 20);
        rc(ADDR_SIN, 32'h9876);
        cmp({16'h0, outWord}, 32'hff00);
        close_out();
    end
endmodule
